// >>> pkg/wvp_pkg.sv
`default_nettype none
package wvp_pkg;
  localparam int VEC_W    = 256;
  localparam int NARROW_W = 128;
  localparam int IDX_W    = 4;
  localparam int REG_CNT  = 16;
  // first payload byte of the prefix: inverted R, X, B and map select
  localparam int B1_R     = 7;
  localparam int B1_X     = 6;
  localparam int B1_B     = 5;
  localparam int B1_MAPHI = 4;
  // second payload byte: W, inverted extra source, length, simd prefix
  localparam int B2_W     = 7;
  localparam int B2_VHI   = 6;
  localparam int B2_VLO   = 3;
  localparam int B2_L     = 2;
  localparam int B2_PPHI  = 1;
  // legacy register extension nibble
  localparam int RX_W     = 3;
  localparam int RX_R     = 2;
  localparam int RX_B     = 0;
  // third source register in the immediate byte
  localparam int IMM_HI   = 7;
  localparam int IMM_LO   = 4;
  localparam logic [4:0] MAP_0F   = 5'h01;
  localparam logic [4:0] MAP_0F38 = 5'h02;
  localparam logic [4:0] MAP_0F3A = 5'h03;

  typedef enum logic [1:0] {
    PFX_NONE = 2'b00,
    PFX_66   = 2'b01,
    PFX_F3   = 2'b10,
    PFX_F2   = 2'b11
  } simd_pfx_e;

  typedef enum logic [1:0] {
    ESC_NONE = 2'b00,
    ESC_0F   = 2'b01,
    ESC_0F38 = 2'b10,
    ESC_0F3A = 2'b11
  } escape_e;

  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [VEC_W-1:0] vec_t;
endpackage
`default_nettype wire

// >>> pkg/dec_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dec_if;
  import wvp_pkg::*;
  logic      hasPrefix;
  logic [7:0] pfxByte1;
  logic [7:0] pfxByte2;
  logic [7:0] imm8;
  logic [3:0] legacyRegExt;
  simd_pfx_e legacyPfx;
  escape_e   legacyEsc;
  logic [2:0] modrmReg;
  logic [2:0] modrmRm;
  logic      mode64;
  logic      isFourOp;
  logic      legacyClassOp;
  simd_pfx_e simdPfx;
  escape_e   escape;
  idx_t      dstIdx;
  idx_t      src1Idx;
  idx_t      src2Idx;
  idx_t      src3Idx;
  logic      wide;
  logic      opW;
  logic      badEncoding;

  modport dec (
    input  hasPrefix, pfxByte1, pfxByte2, imm8, legacyRegExt, legacyPfx,
    input  legacyEsc, modrmReg, modrmRm, mode64, isFourOp, legacyClassOp,
    output simdPfx, escape, dstIdx, src1Idx, src2Idx, src3Idx, wide, opW,
    output badEncoding
  );
  modport top (
    output hasPrefix, pfxByte1, pfxByte2, imm8, legacyRegExt, legacyPfx,
    output legacyEsc, modrmReg, modrmRm, mode64, isFourOp, legacyClassOp,
    input  simdPfx, escape, dstIdx, src1Idx, src2Idx, src3Idx, wide, opW,
    input  badEncoding
  );
endinterface
`default_nettype wire

// >>> rtl/prefix_field_decode.sv
`timescale 1ns/100ps
`default_nettype none
module prefix_field_decode (
  dec_if.dec io
);
  import wvp_pkg::*;

  // outside 64-bit mode only eight registers exist, so the top bit drops
  function automatic idx_t regIdx(input logic hi, input logic [2:0] lo,
                                  input logic m64);
    regIdx = {hi & m64, lo};
  endfunction

  logic [4:0] mapSel;
  logic [3:0] extraSrc;
  logic       mapBad;

  assign mapSel   = io.pfxByte1[B1_MAPHI:0];
  assign extraSrc = ~io.pfxByte2[B2_VHI:B2_VLO];

  always_comb begin
    mapBad = 1'b0;
    if (io.hasPrefix) begin
      io.simdPfx = simd_pfx_e'(io.pfxByte2[B2_PPHI:0]);
      case (mapSel)
        MAP_0F:   io.escape = ESC_0F;
        MAP_0F38: io.escape = ESC_0F38;
        MAP_0F3A: io.escape = ESC_0F3A;
        default: begin
          io.escape = ESC_NONE;
          mapBad    = 1'b1;
        end
      endcase
      io.dstIdx  = regIdx(~io.pfxByte1[B1_R], io.modrmReg, io.mode64);
      io.src2Idx = regIdx(~io.pfxByte1[B1_B], io.modrmRm, io.mode64);
      io.src1Idx = regIdx(extraSrc[3], extraSrc[2:0], io.mode64);
      io.wide    = io.pfxByte2[B2_L];
      io.opW     = io.pfxByte2[B2_W];
    end else begin
      io.simdPfx = io.legacyPfx;
      io.escape  = io.legacyEsc;
      io.dstIdx  = regIdx(io.legacyRegExt[RX_R], io.modrmReg, io.mode64);
      io.src2Idx = regIdx(io.legacyRegExt[RX_B], io.modrmRm, io.mode64);
      // legacy form is destructive: first source is the destination
      io.src1Idx = io.dstIdx;
      io.wide    = 1'b0;
      io.opW     = io.legacyRegExt[RX_W] & io.mode64;
    end
    io.src3Idx = '0;
    if (io.isFourOp) begin
      io.src3Idx = regIdx(io.imm8[IMM_HI], io.imm8[IMM_HI-1:IMM_LO],
                          io.mode64);
    end
    io.badEncoding = io.hasPrefix & (io.legacyClassOp | mapBad);
  end
endmodule
`default_nettype wire

// >>> rtl/wide_vector_prefix_decode.sv
// What this block does
// - 256-bit registers: eight, or sixteen in 64-bit mode
// - narrow view is the low 128 bits
// - unprefixed ops never touch upper 128 bits
// - prefixed 128-bit ops zero bits 255:128
// - third source from immediate bits 7:4
// - prefix carries non-destructive source register
// - simd prefix and escape from prefix fields
// - register extension bits come from prefix
// - refuse prefix on legacy multimedia/float-stack ops
// - prefixed memory ops relax alignment faults
`timescale 1ns/100ps
`default_nettype none
module wide_vector_prefix_decode (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       instValid,
  input  wire logic                       hasPrefix,
  input  wire logic [7:0]                 pfxByte1,
  input  wire logic [7:0]                 pfxByte2,
  input  wire logic [7:0]                 imm8,
  input  wire logic [3:0]                 legacyRegExt,
  input  wire wvp_pkg::simd_pfx_e         legacyPfx,
  input  wire wvp_pkg::escape_e           legacyEsc,
  input  wire logic [2:0]                 modrmReg,
  input  wire logic [2:0]                 modrmRm,
  input  wire logic                       mode64,
  input  wire logic                       isFourOp,
  input  wire logic                       legacyClassOp,
  input  wire logic                       memOperand,
  input  wire logic                       memMisaligned,
  input  wire logic                       strictAlign,
  input  wire logic                       wrEnable,
  input  wire wvp_pkg::vec_t              wrData,
  input  wire wvp_pkg::idx_t              narrowSel,
  output logic                            decValid,
  output logic                            decFault,
  output logic                            alignFault,
  output wvp_pkg::simd_pfx_e              simdPfx,
  output wvp_pkg::escape_e                escape,
  output wvp_pkg::idx_t                   dstIdx,
  output wvp_pkg::idx_t                   src1Idx,
  output wvp_pkg::idx_t                   src2Idx,
  output wvp_pkg::idx_t                   src3Idx,
  output logic                            opWide,
  output logic                            opW,
  output wvp_pkg::vec_t                   src1Data,
  output wvp_pkg::vec_t                   src2Data,
  output wvp_pkg::vec_t                   src3Data,
  output logic [wvp_pkg::NARROW_W-1:0]    narrowData
);
  import wvp_pkg::*;

  dec_if io ();

  assign io.hasPrefix     = hasPrefix;
  assign io.pfxByte1      = pfxByte1;
  assign io.pfxByte2      = pfxByte2;
  assign io.imm8          = imm8;
  assign io.legacyRegExt  = legacyRegExt;
  assign io.legacyPfx     = legacyPfx;
  assign io.legacyEsc     = legacyEsc;
  assign io.modrmReg      = modrmReg;
  assign io.modrmRm       = modrmRm;
  assign io.mode64        = mode64;
  assign io.isFourOp      = isFourOp;
  assign io.legacyClassOp = legacyClassOp;

  prefix_field_decode u_dec (
    .io (io)
  );

  vec_t vecReg [REG_CNT];

  logic misalignBad;
  logic doWrite;

  // unprefixed forms and the few strictly aligned prefixed forms still fault
  assign misalignBad = memOperand & memMisaligned
                       & (~hasPrefix | strictAlign);
  assign doWrite = instValid & wrEnable & ~io.badEncoding & ~misalignBad;

  // an unprefixed read sees only the narrow view
  function automatic vec_t readView(input vec_t v, input logic pfx);
    readView = pfx ? v : {{(VEC_W-NARROW_W){1'b0}}, v[NARROW_W-1:0]};
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_CNT; i++) begin
        vecReg[i] <= '0;
      end
    end else if (doWrite) begin
      if (!hasPrefix) begin
        vecReg[io.dstIdx][NARROW_W-1:0] <= wrData[NARROW_W-1:0];
      end else if (io.wide) begin
        vecReg[io.dstIdx] <= wrData;
      end else begin
        vecReg[io.dstIdx] <= {{(VEC_W-NARROW_W){1'b0}},
                              wrData[NARROW_W-1:0]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      decValid   <= 1'b0;
      decFault   <= 1'b0;
      alignFault <= 1'b0;
      simdPfx    <= PFX_NONE;
      escape     <= ESC_NONE;
      dstIdx     <= '0;
      src1Idx    <= '0;
      src2Idx    <= '0;
      src3Idx    <= '0;
      opWide     <= 1'b0;
      opW        <= 1'b0;
    end else begin
      decValid   <= instValid;
      decFault   <= instValid & io.badEncoding;
      alignFault <= instValid & ~io.badEncoding & misalignBad;
      if (instValid) begin
        simdPfx <= io.simdPfx;
        escape  <= io.escape;
        dstIdx  <= io.dstIdx;
        src1Idx <= io.src1Idx;
        src2Idx <= io.src2Idx;
        src3Idx <= io.src3Idx;
        opWide  <= io.wide;
        opW     <= io.opW;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src1Data <= '0;
      src2Data <= '0;
      src3Data <= '0;
    end else if (instValid) begin
      src1Data <= readView(vecReg[io.src1Idx], hasPrefix);
      src2Data <= readView(vecReg[io.src2Idx], hasPrefix);
      src3Data <= isFourOp ? readView(vecReg[io.src3Idx], hasPrefix)
                           : '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      narrowData <= '0;
    end else begin
      narrowData <= vecReg[narrowSel][NARROW_W-1:0];
    end
  end

  sequence prefixedNarrowWrite;
    doWrite && hasPrefix && !io.wide;
  endsequence

  sequence prefixedWideWrite;
    doWrite && hasPrefix && io.wide;
  endsequence

  sequence legacyWrite;
    doWrite && !hasPrefix;
  endsequence

  a_upper_zeroed: assert property (
    @(posedge mclk) disable iff (!rst_b)
    prefixedNarrowWrite |=>
      vecReg[$past(io.dstIdx)][VEC_W-1:NARROW_W] == '0
      && vecReg[$past(io.dstIdx)][NARROW_W-1:0]
         == $past(wrData[NARROW_W-1:0]))
    else $error("prefixed narrow write left upper bits set");

  a_legacy_upper_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    legacyWrite |=>
      vecReg[$past(io.dstIdx)][VEC_W-1:NARROW_W]
      == $past(vecReg[io.dstIdx][VEC_W-1:NARROW_W]))
    else $error("legacy write changed upper bits");

  a_wide_full_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    prefixedWideWrite |=> vecReg[$past(io.dstIdx)] == $past(wrData))
    else $error("wide write did not store all bits");

  a_narrow_alias: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (doWrite && narrowSel == io.dstIdx) ##1 (narrowSel == $past(narrowSel))
      |=> narrowData == $past(wrData[NARROW_W-1:0], 2))
    else $error("narrow view differs from wide register");

  a_legacy_read_low: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && !hasPrefix) |=> src1Data[VEC_W-1:NARROW_W] == '0
                                  && src2Data[VEC_W-1:NARROW_W] == '0
                                  && src3Data[VEC_W-1:NARROW_W] == '0)
    else $error("legacy read exposed upper bits");

  a_third_source: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && isFourOp && mode64) |=> src3Idx == $past(imm8[IMM_HI:IMM_LO]))
    else $error("third source not taken from immediate");

  a_nd_source_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (doWrite && hasPrefix && io.src1Idx != io.dstIdx) |=>
      vecReg[$past(io.src1Idx)] == $past(vecReg[io.src1Idx])
      && src1Idx == $past(~pfxByte2[B2_VHI:B2_VLO] & {mode64, 3'h7}))
    else $error("non-destructive source changed or misdecoded");

  a_mode32_limit: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && !mode64) |=> !dstIdx[IDX_W-1] && !src1Idx[IDX_W-1]
                               && !src2Idx[IDX_W-1])
    else $error("register above seven outside 64-bit mode");

  a_legacy_class_ref: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && hasPrefix && legacyClassOp) |=> decFault
      ##0 vecReg[$past(io.dstIdx)] == $past(vecReg[io.dstIdx]))
    else $error("prefix accepted on legacy register class");

  a_align_relaxed: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && hasPrefix && !strictAlign && !io.badEncoding)
      |=> !alignFault)
    else $error("prefixed access faulted on alignment");

  a_escape_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (instValid && hasPrefix && pfxByte1[B1_MAPHI:0] == MAP_0F38) |=>
      escape == ESC_0F38 && simdPfx == $past(pfxByte2[B2_PPHI:0]))
    else $error("escape or simd prefix misdecoded");
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wvp_pkg::*;
  typedef struct {
    logic flt, alg, four, wd, w;
    logic [1:0] sp, es;
    idx_t d, s1, s2, s3;
    vec_t r1, r2, r3;
    logic [NARROW_W-1:0] nr;
  } note_s;
  logic mclk = 1'b0, rst_b = 1'b0, instValid = 1'b0, hasPrefix, mode64;
  logic isFourOp;
  logic legacyClassOp, memOperand, memMisaligned, strictAlign, wrEnable;
  logic [7:0] pfxByte1, pfxByte2, imm8;
  logic [3:0] legacyRegExt;
  logic [2:0] modrmReg, modrmRm;
  simd_pfx_e legacyPfx, simdPfx;
  escape_e legacyEsc, escape;
  idx_t narrowSel, dstIdx, src1Idx, src2Idx, src3Idx;
  vec_t wrData, src1Data, src2Data, src3Data;
  logic decValid, decFault, alignFault, opWide, opW;
  logic [NARROW_W-1:0] narrowData;
  vec_t mdl [REG_CNT] = '{default: '0};
  note_s q[$];
  note_s m;
  logic [31:0] seed = 32'h01b7dff0;
  logic [31:0] rv;
  int fails = 0, checked = 0, cyc = 0;

  wide_vector_prefix_decode i_wide_vector_prefix_decode (
    .mclk(mclk), .rst_b(rst_b), .instValid(instValid),
    .hasPrefix(hasPrefix), .pfxByte1(pfxByte1), .pfxByte2(pfxByte2),
    .imm8(imm8), .legacyRegExt(legacyRegExt), .legacyPfx(legacyPfx),
    .legacyEsc(legacyEsc), .modrmReg(modrmReg), .modrmRm(modrmRm),
    .mode64(mode64), .isFourOp(isFourOp), .legacyClassOp(legacyClassOp),
    .memOperand(memOperand), .memMisaligned(memMisaligned),
    .strictAlign(strictAlign), .wrEnable(wrEnable), .wrData(wrData),
    .narrowSel(narrowSel), .decValid(decValid), .decFault(decFault),
    .alignFault(alignFault), .simdPfx(simdPfx), .escape(escape),
    .dstIdx(dstIdx), .src1Idx(src1Idx), .src2Idx(src2Idx),
    .src3Idx(src3Idx), .opWide(opWide), .opW(opW), .src1Data(src1Data),
    .src2Data(src2Data), .src3Data(src3Data), .narrowData(narrowData)
  );

  always #25 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic vec_t rd(idx_t i);
    return hasPrefix ? mdl[i] : {128'h0, mdl[i][127:0]};
  endfunction

  task automatic cmp(input string nm, input logic [255:0] e, g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // prefixed 256-bit defaults with random operands and data
  task automatic base();
    for (int k = 0; k < 8; k++)
      wrData[k*32 +: 32] = xs();
    rv = xs();
    {imm8, legacyRegExt, modrmReg, modrmRm, narrowSel} = rv[21:0];
    legacyPfx = simd_pfx_e'(rv[23:22]);
    legacyEsc = escape_e'(rv[25:24]);
    {hasPrefix, mode64, wrEnable} = 3'b111;
    {isFourOp, legacyClassOp, memOperand, memMisaligned} = 4'h0;
    strictAlign = 1'b0;
    pfxByte1 = 8'he1;
    pfxByte2 = 8'h7c;
  endtask

  // note the expected answer, update the register model, present it
  task automatic issue();
    note_s n;
    logic [4:0] mp;
    logic r, b;
    mp = pfxByte1[4:0];
    n.flt = hasPrefix & (legacyClassOp | mp == 5'h00 | mp > 5'h03);
    n.alg = ~n.flt & memOperand & memMisaligned & (~hasPrefix | strictAlign);
    r = mode64 & (hasPrefix ? ~pfxByte1[7] : legacyRegExt[2]);
    b = mode64 & (hasPrefix ? ~pfxByte1[5] : legacyRegExt[0]);
    n.d = {r, modrmReg};
    n.s2 = {b, modrmRm};
    n.s1 = hasPrefix ? {mode64 & ~pfxByte2[6], ~pfxByte2[5:3]} : n.d;
    n.s3 = isFourOp ? {mode64 & imm8[7], imm8[6:4]} : 4'h0;
    n.sp = hasPrefix ? pfxByte2[1:0] : legacyPfx;
    n.es = hasPrefix ? mp[1:0] : legacyEsc;
    n.wd = hasPrefix & pfxByte2[2];
    n.w = hasPrefix ? pfxByte2[7] : mode64 & legacyRegExt[3];
    n.r1 = rd(n.s1);
    n.r2 = rd(n.s2);
    n.r3 = rd(n.s3);
    n.four = isFourOp;
    n.nr = mdl[narrowSel][NARROW_W-1:0];
    q.push_back(n);
    if (wrEnable & ~n.flt & ~n.alg)
      mdl[n.d] = n.wd ? wrData : {(hasPrefix ? 128'h0 :
                                   mdl[n.d][255:128]), wrData[127:0]};
    instValid = 1'b1;
    @(negedge mclk);
  endtask

  task automatic rd15(input logic p);
    base();
    hasPrefix = p;
    legacyRegExt = 4'h4;
    modrmReg = 3'h7;
    pfxByte2 = 8'h04;
    wrEnable = 0;
    narrowSel = 4'hf;
    issue();
  endtask

  always @(posedge mclk) begin
    #1;
    if (decValid === 1'b1) begin
      if (q.size() == 0)
        cmp("spurious decValid", 0, 1);
      else begin
        m = q.pop_front();
        cmp("decFault", m.flt, decFault);
        cmp("alignFault", m.alg, alignFault);
        cmp("narrowData", m.nr, narrowData);
        if (!(m.flt | m.alg)) begin
          cmp("simdPfx", m.sp, simdPfx);
          cmp("escape", m.es, escape);
          cmp("dstIdx", m.d, dstIdx);
          cmp("src1Idx", m.s1, src1Idx);
          cmp("src2Idx", m.s2, src2Idx);
          cmp("src3Idx", m.s3, src3Idx);
          cmp("opWide", m.wd, opWide);
          cmp("opW", m.w, opW);
          cmp("src1Data", m.r1, src1Data);
          cmp("src2Data", m.r2, src2Data);
          if (m.four)
            cmp("src3Data", m.r3, src3Data);
        end
      end
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    base();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    // widest write to register 15, then partial-width updates on top
    base();
    pfxByte1 = 8'h61;
    modrmReg = 3'h7;
    narrowSel = 4'hf;
    issue();
    rd15(1'b1);
    rd15(1'b0);
    base();
    hasPrefix = 1'b0;
    legacyRegExt = 4'h4;
    modrmReg = 3'h7;
    narrowSel = 4'hf;
    issue();
    rd15(1'b1);
    rd15(1'b0);
    base();
    pfxByte1 = 8'h61;
    modrmReg = 3'h7;
    pfxByte2 = 8'h78;
    narrowSel = 4'hf;
    issue();
    rd15(1'b1);
    $display("test register views done");
    for (int i = 0; i < 32; i++) begin
      base();
      rv = xs();
      hasPrefix = i < 24;
      mode64 = i[2];
      isFourOp = i[3];
      wrEnable = rv[8];
      pfxByte1 = {rv[7:5], 5'(i % 3 + 1)};
      pfxByte2 = {rv[15:10], i[1:0]};
      legacyPfx = simd_pfx_e'(i[1:0]);
      legacyEsc = escape_e'(i[1:0]);
      issue();
    end
    $display("test field decode done");
    for (int i = 0; i < 4; i++) begin
      base();
      hasPrefix = i != 3;
      legacyClassOp = i[0];
      pfxByte1 = i == 0 ? 8'he0 : (i == 2 ? 8'hff : 8'he1);
      issue();
    end
    $display("test refusal done");
    for (int i = 0; i < 4; i++) begin
      base();
      memOperand = 1;
      memMisaligned = i != 3;
      hasPrefix = i != 1;
      strictAlign = i == 2;
      issue();
    end
    $display("test alignment done");
    instValid = 1'b0;
    repeat (3) @(negedge mclk);
    cmp("pending notes", 0, q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
